//--- pkg/taep_defines.svh
// register map, field positions, reset values and counts of the encoder/pwm block
`ifndef TAEP_DEFINES_SVH
`define TAEP_DEFINES_SVH

// ****************************************************************
// register byte offsets inside the 256-byte window
// ****************************************************************
`define TAEP_WINDOW_BYTES 256
`define TAEP_OFF_VERSION 8'h00
`define TAEP_OFF_APP_ID 8'h04
`define TAEP_OFF_ENC_AZ 8'h08
`define TAEP_OFF_ENC_PI 8'h0C
`define TAEP_OFF_ENC_HOLD 8'h10
`define TAEP_OFF_CTRL_AZ 8'h14
`define TAEP_OFF_CTRL_PI 8'h18
`define TAEP_OFF_DIV_AZ 8'h1C
`define TAEP_OFF_DIV_PI 8'h20
`define TAEP_OFF_THERMAL 8'h24
`define TAEP_OFF_IRQ_STAT 8'h28
`define TAEP_OFF_IRQ_MASK 8'h2C

// ****************************************************************
// field positions
// ****************************************************************
`define TAEP_THERM_STAT_LSB 8
`define TAEP_IRQ_HOT_LSB 0
`define TAEP_IRQ_WRAP_LSB 2

// ****************************************************************
// reset values
// ****************************************************************
`define TAEP_RST_ENC_HOLD 2'h0
`define TAEP_RST_THERM_EN 2'h3
`define TAEP_RST_IRQ_MASK 4'h0

// ****************************************************************
// counts
// ****************************************************************
`define TAEP_PWM_STEPS 1023
`define TAEP_PWM_LAST 10'h3FE
`define TAEP_PWM_FULL 10'h3FF
`define TAEP_REF_KHZ 40000

`endif

//--- pkg/taep_pkg.sv
// types shared by the encoder/pwm block
`default_nettype none
package taep_pkg;
  typedef logic signed [15:0] taep_pos_t;  // encoder position
  typedef logic signed [10:0] taep_ctrl_t; // signed motor control, -1023..1023 = -1.0..1.0
  typedef logic [3:0] taep_irq_t;          // two overheat onsets, two position wraps
endpackage : taep_pkg
`default_nettype wire

//--- rtl/taep_encoder.sv
// quadrature encoder position counter with reset hold
`timescale 1ns/100ps
`default_nettype none

module taep_encoder import taep_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic hold,
  output taep_pos_t position,
  output logic wrap
);

  logic a_ff; // previous sample of phase a
  logic b_ff; // previous sample of phase b
  taep_pos_t pos_ff;
  logic wrap_ff;
  logic step;
  logic up;

  // exactly one phase changed: one quarter step; both changed is a skipped step, ignored
  assign step = (enc_a ^ a_ff) ^ (enc_b ^ b_ff);
  // direction from new a against old b
  assign up = enc_a ^ b_ff;

  // ****************************************************************
  // input history, tracked even in hold so release gives no false step
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_ff <= 1'b0;
      b_ff <= 1'b0;
    end else begin
      a_ff <= enc_a;
      b_ff <= enc_b;
    end
  end

  // ****************************************************************
  // position counter, wraps modulo 65536
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_ff <= 16'sh0000;
      wrap_ff <= 1'b0;
    end else if (hold) begin
      pos_ff <= 16'sh0000; // reads zero while held
      wrap_ff <= 1'b0;
    end else if (step) begin
      pos_ff <= up ? pos_ff + 16'sh0001 : pos_ff - 16'sh0001;
      // signed overflow either way marks a wrap event
      wrap_ff <= up ? (pos_ff == 16'sh7FFF) : (pos_ff == 16'sh8000);
    end else begin
      wrap_ff <= 1'b0;
    end
  end

  assign position = pos_ff;
  assign wrap = wrap_ff;

endmodule : taep_encoder

`default_nettype wire

//--- rtl/taep_pwm.sv
// signed pwm generator with its own clock divider and thermal cut-off
`timescale 1ns/100ps
`default_nettype none
`include "taep_defines.svh"

module taep_pwm import taep_pkg::*; #(
  parameter int DIV_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire taep_ctrl_t ctrl,
  input wire logic [DIV_W-1:0] pwm_clock_divider,
  input wire logic force_off,
  output logic pwm_out,
  output logic pwm_dir
);

  logic [DIV_W-1:0] pre_ff; // divider count
  logic [9:0] per_ff;       // position in the 1023-step period
  logic pwm_ff;
  logic dir_ff;
  logic step;
  logic [10:0] mag_full;
  logic [9:0] mag;

  // one step every (1 + divider) clocks; >= covers a divider lowered mid-count
  assign step = (pre_ff >= pwm_clock_divider);

  // magnitude of the control; -1024 saturates to full duty
  always_comb begin
    mag_full = ctrl[10] ? 11'(-ctrl) : 11'(ctrl);
    mag = mag_full[10] ? `TAEP_PWM_FULL : mag_full[9:0];
  end

  // ****************************************************************
  // prescaler
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= '0;
    end else if (step) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + 1'b1;
    end
  end

  // ****************************************************************
  // period counter, 0..1022
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_ff <= 10'h000;
    end else if (step) begin
      per_ff <= (per_ff == `TAEP_PWM_LAST) ? 10'h000 : per_ff + 10'h001;
    end
  end

  // ****************************************************************
  // output stage: magnitude sets duty, sign sets direction
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_ff <= 1'b0;
      dir_ff <= 1'b0;
    end else begin
      pwm_ff <= ~force_off & (per_ff < mag);
      dir_ff <= ctrl[10];
    end
  end

  assign pwm_out = pwm_ff;
  assign pwm_dir = dir_ff;

endmodule : taep_pwm

`default_nettype wire

//--- rtl/taep_top.sv
// top of the two-axis encoder and pwm i/o block with its apb register file
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "taep_defines.svh"

module taep_top import taep_pkg::*; #(
  parameter logic [31:0] LOGIC_VERSION = 32'h0000_0001, // arbitrary value
  parameter logic [31:0] APP_ID = 32'h5249_4731,        // arbitrary four characters
  parameter int DIV_W = 8                               // width of each pwm divider
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] enc_a,
  input wire logic [1:0] enc_b,
  input wire logic [1:0] amp_hot,
  output logic [1:0] pwm_out,
  output logic [1:0] pwm_dir,
  output logic irq
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [1:0] enc_hold_ff;              // per-axis encoder hold, bit0 azimuth
  taep_ctrl_t ctrl_ff [2];              // per-axis signed control
  logic [DIV_W-1:0] div_ff [2];         // per-axis pwm clock divider
  logic [1:0] therm_en_ff;              // thermal cut-off enable flags
  logic [1:0] hot_ff;                   // registered amplifier overheat
  taep_irq_t irq_stat_ff;               // sticky event bits
  taep_irq_t irq_mask_ff;               // interrupt enables
  logic [31:0] prdata_ff;               // read data, loaded in setup phase
  logic pslverr_ff;                     // error answer, loaded in setup phase
  logic [31:0] nxt_prdata;
  logic nxt_pslverr;
  taep_pos_t position [2];              // encoder outputs
  logic [1:0] wrap;                     // encoder wrap pulses
  logic setup;                          // apb setup phase
  logic wr;                             // write takes effect this edge
  logic [7:0] word_addr;                // word-aligned offset inside the window
  logic hit;                            // offset is mapped
  taep_irq_t irq_set;                   // events raised this cycle
  taep_irq_t irq_clr;                   // bits software clears this cycle

  // ****************************************************************
  // apb decode
  // ****************************************************************
  // the system decoder asserts psel anywhere in the window it assigned,
  // so the block never compares against a base of its own
  assign setup = psel & ~penable;
  // zero wait states: every access completes in its first access cycle
  assign wr = psel & penable & pwrite;
  // only the low eight address bits matter inside the window
  assign word_addr = {paddr[7:2], 2'b00};

  // offset is one of the documented words
  always_comb begin
    unique case (word_addr)
      `TAEP_OFF_VERSION,
      `TAEP_OFF_APP_ID,
      `TAEP_OFF_ENC_AZ,
      `TAEP_OFF_ENC_PI,
      `TAEP_OFF_ENC_HOLD,
      `TAEP_OFF_CTRL_AZ,
      `TAEP_OFF_CTRL_PI,
      `TAEP_OFF_DIV_AZ,
      `TAEP_OFF_DIV_PI,
      `TAEP_OFF_THERMAL,
      `TAEP_OFF_IRQ_STAT,
      `TAEP_OFF_IRQ_MASK: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0; // rest of the window is unmapped
      end
    endcase
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    nxt_pslverr = ~hit;
    unique case (word_addr)
      `TAEP_OFF_VERSION: begin
        nxt_prdata = LOGIC_VERSION;
      end
      `TAEP_OFF_APP_ID: begin
        nxt_prdata = APP_ID;
      end
      `TAEP_OFF_ENC_AZ: begin
        nxt_prdata = {16'h0000, position[0]};
      end
      `TAEP_OFF_ENC_PI: begin
        nxt_prdata = {16'h0000, position[1]};
      end
      `TAEP_OFF_ENC_HOLD: begin
        nxt_prdata = {30'h0000_0000, enc_hold_ff};
      end
      `TAEP_OFF_CTRL_AZ: begin
        nxt_prdata = {21'h00_0000, ctrl_ff[0]};
      end
      `TAEP_OFF_CTRL_PI: begin
        nxt_prdata = {21'h00_0000, ctrl_ff[1]};
      end
      `TAEP_OFF_DIV_AZ: begin
        nxt_prdata = 32'(div_ff[0]);
      end
      `TAEP_OFF_DIV_PI: begin
        nxt_prdata = 32'(div_ff[1]);
      end
      `TAEP_OFF_THERMAL: begin
        // flags in the low bits, live amplifier status above them
        nxt_prdata[1:0] = therm_en_ff;
        nxt_prdata[`TAEP_THERM_STAT_LSB +: 2] = hot_ff;
      end
      `TAEP_OFF_IRQ_STAT: begin
        nxt_prdata = {28'h000_0000, irq_stat_ff};
      end
      `TAEP_OFF_IRQ_MASK: begin
        nxt_prdata = {28'h000_0000, irq_mask_ff};
      end
      default: begin
        nxt_prdata = 32'h0000_0000; // unmapped reads as zero with an error
      end
    endcase
  end

  // read data and error are captured in the setup phase, so they stand
  // stable through the whole access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff & psel & penable;
  assign pready = 1'b1;

  // ****************************************************************
  // encoder hold register
  // ****************************************************************
  // hold resets to released; software sets it to zero an axis
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_hold_ff <= `TAEP_RST_ENC_HOLD;
    end else if (wr && word_addr == `TAEP_OFF_ENC_HOLD) begin
      enc_hold_ff <= pwdata[1:0];
    end
  end

  // ****************************************************************
  // control and divider registers, one pair per axis
  // ****************************************************************
  // writing zero to both controls is how software stops the motors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff[0] <= 11'sh000;
      ctrl_ff[1] <= 11'sh000;
    end else if (wr) begin
      if (word_addr == `TAEP_OFF_CTRL_AZ) begin
        ctrl_ff[0] <= pwdata[10:0];
      end
      if (word_addr == `TAEP_OFF_CTRL_PI) begin
        ctrl_ff[1] <= pwdata[10:0];
      end
    end
  end

  // dividers take effect at once; the running prescaler count is compared against the new value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff[0] <= '0;
      div_ff[1] <= '0;
    end else if (wr) begin
      if (word_addr == `TAEP_OFF_DIV_AZ) begin
        div_ff[0] <= pwdata[DIV_W-1:0];
      end
      if (word_addr == `TAEP_OFF_DIV_PI) begin
        div_ff[1] <= pwdata[DIV_W-1:0];
      end
    end
  end

  // ****************************************************************
  // thermal flags and status
  // ****************************************************************
  // flags reset to set so an overheated amplifier is protected from power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      therm_en_ff <= `TAEP_RST_THERM_EN;
    end else if (wr && word_addr == `TAEP_OFF_THERMAL) begin
      therm_en_ff <= pwdata[1:0];
    end
  end

  // one register stage on the amplifier pins; also the edge reference
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hot_ff <= 2'h0;
    end else begin
      hot_ff <= amp_hot;
    end
  end

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  // events: overheat onset per axis, position wrap per axis
  assign irq_set = {wrap, amp_hot & ~hot_ff};
  assign irq_clr = (wr && word_addr == `TAEP_OFF_IRQ_STAT) ? pwdata[3:0] : 4'h0;

  // write one to clear; an event in the clearing cycle still sets the bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= 4'h0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_ff <= `TAEP_RST_IRQ_MASK;
    end else if (wr && word_addr == `TAEP_OFF_IRQ_MASK) begin
      irq_mask_ff <= pwdata[3:0];
    end
  end

  // level interrupt while any unmasked bit stands
  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ****************************************************************
  // per-axis datapath: index 0 azimuth, 1 pitch
  // ****************************************************************
  for (genvar i = 0; i < 2; i++) begin : g_axis
    // quadrature position counter with hold
    taep_encoder u_enc (
      .pclk(pclk),
      .presetn(presetn),
      .enc_a(enc_a[i]),
      .enc_b(enc_b[i]),
      .hold(enc_hold_ff[i]),
      .position(position[i]),
      .wrap(wrap[i])
    );

    // pwm drive; cut off only on this axis's own overheat and flag
    taep_pwm #(
      .DIV_W(DIV_W)
    ) u_pwm (
      .pclk(pclk),
      .presetn(presetn),
      .ctrl(ctrl_ff[i]),
      .pwm_clock_divider(div_ff[i]),
      .force_off(hot_ff[i] & therm_en_ff[i]),
      .pwm_out(pwm_out[i]),
      .pwm_dir(pwm_dir[i])
    );
  end

endmodule : taep_top

`default_nettype wire

//--- dv/taep_properties.sv
// port-level assertions for the encoder/pwm top and their bind
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// checker
// ****************************************
module taep_checker #(
  parameter logic [31:0] LOGIC_VERSION = 32'h0000_0001,
  parameter logic [31:0] APP_ID = 32'h0000_0000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [1:0] amp_hot,
  input wire logic [1:0] pwm_out,
  input wire logic [1:0] pwm_dir,
  input wire logic irq
);
  logic [1:0] flag_ff; // shadow of the cut-off flags
  logic [1:0] hold_ff; // shadow of the hold bits
  logic [3:0] mask_ff; // shadow of the irq mask
  logic wr; // write completing at this edge
  logic rd_setup; // read setup cycle
  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  // shadows move at the same edge as the design's registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_ff <= 2'h3;
      hold_ff <= 2'h0;
      mask_ff <= 4'h0;
    end else if (wr) begin
      if (paddr == 8'h24) flag_ff <= pwdata[1:0];
      if (paddr == 8'h10) hold_ff <= pwdata[1:0];
      if (paddr == 8'h2C) mask_ff <= pwdata[3:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  unmapped_err_a: assert property (psel && penable && paddr >= 8'h30 |-> pslverr)
    else $error("unmapped offset without error");
  mapped_ok_a: assert property (psel && penable && paddr < 8'h30 |-> !pslverr)
    else $error("mapped offset flagged");
  version_read_a: assert property (rd_setup && paddr[7:2] == 6'h00 |=> prdata == LOGIC_VERSION)
    else $error("version word wrong");
  app_read_a: assert property (rd_setup && paddr[7:2] == 6'h01 |=> prdata == APP_ID)
    else $error("application word wrong");
  held_zero_a: assert property (rd_setup && paddr[7:2] == 6'h02 && hold_ff[0] && $past(hold_ff[0])
    |=> prdata == 32'h0000_0000) else $error("held position not zero");
  hot_cut_a: assert property ($past(amp_hot[0], 2) && $past(flag_ff[0]) |-> !pwm_out[0])
    else $error("pwm not cut while hot");
  irq_masked_a: assert property (mask_ff == 4'h0 |-> !irq)
    else $error("irq while fully masked");
  dir_sign_a: assert property (wr && paddr == 8'h14 |-> ##2 pwm_dir[0] == $past(pwdata[10], 2))
    else $error("direction differs from sign");
  stop_off_a: assert property (wr && paddr == 8'h14 && pwdata[10:0] == 11'h000
    |-> ##2 (!pwm_out[0]) [*4]) else $error("pwm on after zero control");
endmodule : taep_checker
bind taep_top taep_checker #(.LOGIC_VERSION(LOGIC_VERSION), .APP_ID(APP_ID)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .amp_hot(amp_hot),
  .pwm_out(pwm_out), .pwm_dir(pwm_dir), .irq(irq));
`default_nettype wire

//--- dv/taep_rig_model.sv
// behavioural rig: two quadrature encoders and two amplifiers
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// rig model
// ****************************************
module taep_rig_model (
  input wire logic pclk,
  output logic [1:0] enc_a,
  output logic [1:0] enc_b,
  output logic [1:0] amp_hot
);
  int phase [2]; // gray phase 0..3 per axis
  // encoders at rest, amplifiers cool
  initial begin
    enc_a = 2'h0;
    enc_b = 2'h0;
    amp_hot = 2'h0;
    phase = '{0, 0};
  end
  // one gray step per edge, never both phases at once
  task automatic step(input int ax, input int dir, input int n);
    repeat (n) begin
      @(posedge pclk);
      phase[ax] = (phase[ax] + dir) & 3;
      enc_a[ax] <= (phase[ax] == 1) || (phase[ax] == 2);
      enc_b[ax] <= phase[ax] >= 2;
    end
  endtask : step
  // amplifier reports overheating as a level
  task automatic heat(input int ax, input logic v);
    @(posedge pclk);
    amp_hot[ax] <= v;
  endtask : heat
endmodule : taep_rig_model
`default_nettype wire

//--- dv/tb.sv
// self-checking bench for the encoder/pwm top
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// bench top
// ****************************************
module tb;
  localparam logic [31:0] VER = 32'h0000_0002; // arbitrary value
  localparam logic [31:0] AID = 32'h4142_4344; // arbitrary value
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic rerr; // error seen on last transfer
  logic [1:0] enc_a, enc_b, amp_hot, pwm_out, pwm_dir;
  int num_errors = 0;
  int checks_done = 0;
  int cnt; // pwm high cycles
  logic [7:0] offs [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20,
    8'h24, 8'h28, 8'h2C};
  logic [31:0] rstv [12] = '{VER, AID, 0, 0, 0, 0, 0, 0, 0, 32'h0000_0003, 0, 0};
  logic [10:0] pc [5] = '{11'h002, 11'h002, 11'h7FE, 11'h400, 11'h3FF}; // controls
  int pd [5] = '{0, 1, 0, 0, 2}; // dividers
  int pe [5] = '{2, 4, 2, 1023, 3069}; // high cycles per full period
  taep_top #(.LOGIC_VERSION(VER), .APP_ID(AID)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b),
    .amp_hot(amp_hot), .pwm_out(pwm_out), .pwm_dir(pwm_dir), .irq(irq));
  taep_rig_model rig (.pclk(pclk), .enc_a(enc_a), .enc_b(enc_b), .amp_hot(amp_hot));
  always #50 pclk = ~pclk;
  // verdict and end of run
  task automatic close_out;
    if (num_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic count(input int ax, input int n);
    cnt = 0;
    repeat (n) begin
      @(posedge pclk);
      cnt += (pwm_out[ax] === 1'b1);
    end
  endtask : count
  // watchdog: the whole sequence needs roughly 41400 cycles
  initial begin
    repeat (80000) @(posedge pclk);
    num_errors++;
    close_out();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      apb(1'b0, offs[i], 32'h0000_0000);
      check(rdata, rstv[i]);
    end
    apb(1'b0, 8'hFC, 32'h0000_0000);
    check(32'(rerr), 32'h0000_0001);
    check(32'(pready), 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_FFFF);
    apb(1'b0, 8'h00, 32'h0000_0000);
    check(rdata, VER);
    // encoders both ways, then hold and release of azimuth
    rig.step(0, 1, 5);
    rig.step(1, -1, 3);
    apb(1'b0, 8'h08, 32'h0000_0000);
    check(32'(rdata[15:0]), 32'h0000_0005);
    apb(1'b1, 8'h10, 32'h0000_0001);
    rig.step(0, 1, 4);
    apb(1'b0, 8'h08, 32'h0000_0000);
    check(32'(rdata[15:0]), 32'h0000_0000);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    check(32'(rdata[15:0]), 32'h0000_FFFD);
    apb(1'b1, 8'h10, 32'h0000_0000);
    rig.step(0, 1, 2);
    apb(1'b0, 8'h08, 32'h0000_0000);
    check(32'(rdata[15:0]), 32'h0000_0002);
    // run azimuth across the signed boundary
    rig.step(0, 1, 32766);
    apb(1'b0, 8'h08, 32'h0000_0000);
    check(32'(rdata[15:0]), 32'h0000_8000);
    apb(1'b0, 8'h28, 32'h0000_0000);
    check(rdata, 32'h0000_0004);
    // irq follows the register written at the access edge, so look one edge later
    apb(1'b1, 8'h2C, 32'h0000_0004);
    @(posedge pclk);
    check(32'(irq), 32'h0000_0001);
    apb(1'b1, 8'h28, 32'h0000_0004);
    @(posedge pclk);
    check(32'(irq), 32'h0000_0000);
    // overheat on azimuth only, with full drive on both axes
    apb(1'b1, 8'h18, 32'h0000_03FF);
    apb(1'b1, 8'h14, 32'h0000_03FF);
    rig.heat(0, 1'b1);
    repeat (4) @(posedge pclk);
    apb(1'b0, 8'h24, 32'h0000_0000);
    check(rdata, 32'h0000_0103);
    count(0, 50);
    check(cnt, 0);
    count(1, 50);
    check(cnt, 50);
    check(32'(pwm_dir[1]), 32'h0000_0000);
    apb(1'b1, 8'h24, 32'h0000_0002);
    repeat (3) @(posedge pclk);
    count(0, 50);
    check(cnt, 50);
    rig.heat(0, 1'b0);
    apb(1'b1, 8'h24, 32'h0000_0003);
    apb(1'b1, 8'h2C, 32'h0000_0001);
    @(posedge pclk);
    check(32'(irq), 32'h0000_0001);
    apb(1'b1, 8'h2C, 32'h0000_0000);
    @(posedge pclk);
    check(32'(irq), 32'h0000_0000);
    apb(1'b1, 8'h2C, 32'h0000_0001);
    apb(1'b1, 8'h28, 32'h0000_0001);
    @(posedge pclk);
    check(32'(irq), 32'h0000_0000);
    // duty and rate over one whole period per setting
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 8'h14, 32'(pc[i]));
      apb(1'b1, 8'h1C, 32'(pd[i]));
      repeat (10) @(posedge pclk);
      count(0, 1023 * (1 + pd[i]));
      check(cnt, pe[i]);
      check(32'(pwm_dir[0]), 32'(pc[i][10]));
    end
    // stop: zero control on both axes
    apb(1'b1, 8'h14, 32'h0000_0000);
    apb(1'b1, 8'h18, 32'h0000_0000);
    // the pwm output stage lags the control register by one edge
    repeat (2) @(posedge pclk);
    count(1, 100);
    check(cnt, 0);
    close_out();
  end
endmodule : tb
`default_nettype wire
